// *** bench/tb_rtcb_top.sv ***
// Self-checking bench for the backup-domain real-time clock.
// Assumes source clock pins are slow pulse trains, two cycles high and three low, made here from the core clock.
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    samples_checked++; \
    if ((got) !== (ex)) \
    begin \
      $display("ERROR %s expected %h seen %h", nm, ex, got); \
      bad_count++; \
    end \
  end
module tb_rtcb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic bkp_rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [2:0] src = 3'h0; // Crystal, RC, fast pins
  logic wake = 1'b0;
  logic pin_rst_n = 1'b1;
  logic wdog = 1'b0;
  logic stby = 1'b0;
  logic alarm_irq, tick_irq, alarm_ev, stby_exit, cal, cal_q;
  int bad_count = 0;
  int samples_checked = 0;
  int ev_n = 0;
  int exit_n = 0;
  int cal_n = 0;
  logic [31:0] d;
  logic [31:0] base;
  // Short first division keeps the run short; the one-second default is checked as a constant
  localparam int FIRST_TICK = 256;

  rtcb_top #(.RESET_RELOAD(20'(FIRST_TICK - 1))) dut (.CORE_CLK_IN(clk), .RST_IN(rst),
    .BKP_RST_IN(bkp_rst),
    .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd),
    .REG_RDATA_OUT(rdata), .SLOW_XTAL_CLK_IN(src[0]), .LOW_POWER_RC_CLK_IN(src[1]),
    .FAST_EXTERNAL_CLOCK_IN(src[2]), .WAKEUP_PIN_IN(wake),
    .EXTERNAL_RESET_PIN_N_IN(pin_rst_n), .INDEPENDENT_WATCHDOG_RST_IN(wdog),
    .STANDBY_IN(stby), .ALARM_IRQ_OUT(alarm_irq), .TICK_IRQ_OUT(tick_irq),
    .ALARM_EVENT_OUT(alarm_ev), .STANDBY_EXIT_OUT(stby_exit), .CAL_CLK_OUT(cal));

  // 250 MHz core clock
  always #2 clk = ~clk;

  // Event counters; outputs are one-cycle pulses, so one edge is one event
  always @(posedge clk)
  begin
    if (alarm_ev === 1'b1) ev_n++;
    if (stby_exit === 1'b1) exit_n++;
    if (cal !== cal_q) cal_n++;
    cal_q <= cal;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Two cycles high, three low keeps the pin under the sampling limit
  task automatic edges(input int k, input int n);
    repeat (n)
    begin
      @(posedge clk);
      src[k] <= 1'b1;
      repeat (2) @(posedge clk);
      src[k] <= 1'b0;
      repeat (2) @(posedge clk);
    end
    repeat (8) @(posedge clk);
  endtask

  task automatic t_reset();
    `CHK("reload default", 32'h7fff, 32'(rtcb_pkg::RELOAD_RESET))
    rd_reg(rtcb_pkg::OFF_CTRL);
    `CHK("ctrl", 32'h0, d)
    rd_reg(rtcb_pkg::OFF_RELOAD);
    `CHK("reload", 32'(FIRST_TICK - 1), d)
    rd_reg(rtcb_pkg::OFF_DIVIDER);
    `CHK("divider", 32'(FIRST_TICK - 1), d)
    rd_reg(rtcb_pkg::OFF_COUNT);
    `CHK("count", 32'h0, d)
    rd_reg(rtcb_pkg::OFF_ALARM);
    `CHK("alarm", 32'hffffffff, d)
    rd_reg(rtcb_pkg::OFF_STATUS);
    `CHK("status", 32'h0, d)
    rd_reg(8'h80);
    `CHK("unmapped", 32'h0, d)
  endtask

  // Backup words keep 16 bits and survive a main reset taken in Standby
  task automatic t_backup();
    rd_reg(8'h44);
    `CHK("bkp reset", 32'h0, d)
    for (int i = 0; i < 10; i++)
      wr_reg(8'h20 + 8'(4 * i), {16'hffff, 16'ha5a0 + 16'(i)});
    for (int i = 0; i < 10; i++)
    begin
      rd_reg(8'h20 + 8'(4 * i));
      `CHK("bkp", {16'h0, 16'ha5a0 + 16'(i)}, d)
    end
    wr_reg(rtcb_pkg::OFF_CTRL, 32'h2);
    stby <= 1'b1;
    wr_reg(8'h20, 32'h1234);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    stby <= 1'b0;
    rd_reg(8'h20);
    `CHK("bkp kept", 32'ha5a0, d)
    rd_reg(rtcb_pkg::OFF_CTRL);
    `CHK("ctrl lost", 32'h0, d)
  endtask

  // First tick needs the full reset division; the new reload waits for it
  task automatic t_count();
    wr_reg(rtcb_pkg::OFF_CTRL, 32'h2);
    wr_reg(rtcb_pkg::OFF_RELOAD, 32'h3);
    edges(0, 100);
    rd_reg(rtcb_pkg::OFF_DIVIDER);
    `CHK("divider run", 32'(FIRST_TICK - 101), d)
    edges(0, FIRST_TICK - 101);
    rd_reg(rtcb_pkg::OFF_COUNT);
    `CHK("count early", 32'h0, d)
    `CHK("tick irq early", 1'b0, tick_irq)
    edges(0, 1);
    rd_reg(rtcb_pkg::OFF_COUNT);
    `CHK("count 1s", 32'h1, d)
    `CHK("tick irq", 1'b1, tick_irq)
    rd_reg(rtcb_pkg::OFF_DIVIDER);
    `CHK("reloaded", 32'h3, d)
    edges(0, 8);
    rd_reg(rtcb_pkg::OFF_COUNT);
    `CHK("count short", 32'h3, d)
    wr_reg(rtcb_pkg::OFF_STATUS, 32'h2);
    repeat (3) @(posedge clk);
    #1;
    `CHK("tick cleared", 1'b0, tick_irq)
    wr_reg(rtcb_pkg::OFF_CTRL, 32'h0);
    edges(0, 4);
    rd_reg(rtcb_pkg::OFF_STATUS);
    `CHK("tick flag", 32'h2, d)
    `CHK("tick gated", 1'b0, tick_irq)
  endtask

  // Alarm while in Standby: reload is 3, so 8 edges reach 6 and 16 reach 8
  task automatic t_alarm();
    wr_reg(rtcb_pkg::OFF_STATUS, 32'h3);
    wr_reg(rtcb_pkg::OFF_ALARM, 32'h6);
    wr_reg(rtcb_pkg::OFF_CTRL, 32'h1);
    ev_n = 0;
    exit_n = 0;
    stby <= 1'b1;
    edges(0, 16);
    stby <= 1'b0;
    `CHK("alarm events", 1, ev_n)
    `CHK("alarm exit", 1, exit_n)
    rd_reg(rtcb_pkg::OFF_COUNT);
    `CHK("count standby", 32'h8, d)
    `CHK("alarm irq", 1'b1, alarm_irq)
    rd_reg(rtcb_pkg::OFF_STATUS);
    `CHK("both flags", 32'h3, d)
    wr_reg(rtcb_pkg::OFF_CTRL, 32'h0);
    repeat (3) @(posedge clk);
    #1;
    `CHK("alarm gated", 1'b0, alarm_irq)
    wr_reg(rtcb_pkg::OFF_STATUS, 32'h3);
  endtask

  // Only the documented edges end Standby, and only in Standby
  task automatic t_exits();
    exit_n = 0;
    stby <= 1'b1;
    wake <= 1'b1;
    repeat (10) @(posedge clk);
    wake <= 1'b0;
    repeat (10) @(posedge clk);
    `CHK("wake rise", 1, exit_n)
    pin_rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    pin_rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK("reset pin", 2, exit_n)
    wdog <= 1'b1;
    @(posedge clk);
    wdog <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK("watchdog", 3, exit_n)
    stby <= 1'b0;
    wdog <= 1'b1;
    @(posedge clk);
    wdog <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK("no standby", 3, exit_n)
  endtask

  // The RC and fast sources each count alone once the reload is zero; off counts nothing
  task automatic t_sources();
    wr_reg(rtcb_pkg::OFF_RELOAD, 32'h0);
    edges(0, 4);
    rd_reg(rtcb_pkg::OFF_COUNT);
    base = d;
    wr_reg(rtcb_pkg::OFF_CTRL, 32'h10);
    edges(0, 3);
    edges(1, 3);
    rd_reg(rtcb_pkg::OFF_COUNT);
    `CHK("rc source", base + 32'd3, d)
    wr_reg(rtcb_pkg::OFF_CTRL, 32'h20);
    edges(1, 2);
    edges(2, 256);
    rd_reg(rtcb_pkg::OFF_COUNT);
    `CHK("fast source", base + 32'd5, d)
    wr_reg(rtcb_pkg::OFF_CTRL, 32'h30);
    edges(0, 2);
    edges(1, 2);
    rd_reg(rtcb_pkg::OFF_COUNT);
    `CHK("off source", base + 32'd5, d)
  endtask

  // 64 crystal edges make one full 512 Hz period: two output changes
  task automatic t_cal();
    wr_reg(rtcb_pkg::OFF_CTRL, 32'h4);
    repeat (8) @(posedge clk);
    cal_n = 0;
    edges(0, 64);
    `CHK("cal changes", 2, cal_n)
    edges(0, 32);
    #1;
    `CHK("cal high", 1'b1, cal)
    wr_reg(rtcb_pkg::OFF_CTRL, 32'h0);
    repeat (4) @(posedge clk);
    #1;
    `CHK("cal off", 1'b0, cal)
  endtask

  // The scenarios need under 4000 cycles; five times that means a hang
  initial
  begin
    #(4 * 20000);
    bad_count++;
    conclude();
  end

  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    bkp_rst <= 1'b0;
    t_reset();
    t_backup();
    t_count();
    t_alarm();
    t_exits();
    t_sources();
    t_cal();
    conclude();
  end
endmodule

// *** hdl/rtcb_pkg.sv ***
// Shared constants for the backup-domain real-time clock.
// Assumes a 32-bit register port with byte addresses on an 8-bit address bus.
package rtcb_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_RELOAD = 8'h08;
  localparam logic [7:0] OFF_DIVIDER = 8'h0c;
  localparam logic [7:0] OFF_COUNT = 8'h10;
  localparam logic [7:0] OFF_ALARM = 8'h14;
  localparam logic [7:0] OFF_BKP_BASE = 8'h20;
  localparam logic [7:0] BKP_STRIDE = 8'h04;

  // Control register fields
  localparam int CTRL_ALARM_IE = 0;
  localparam int CTRL_TICK_IE = 1;
  localparam int CTRL_CAL_EN = 2;
  localparam int CTRL_SEL_LO = 4;
  localparam int CTRL_SEL_HI = 5;

  // Status register fields, write one to clear
  localparam int STAT_ALARM = 0;
  localparam int STAT_TICK = 1;

  // Counting clock source codes
  localparam logic [1:0] SEL_SLOW_XTAL = 2'h0;
  localparam logic [1:0] SEL_LOW_POWER_RC = 2'h1;
  localparam logic [1:0] SEL_FAST_DIV = 2'h2;
  localparam logic [1:0] SEL_OFF = 2'h3;

  // Frequencies in Hz and derived divide factors
  localparam int SLOW_XTAL_HZ = 32768;
  localparam int CAL_OUT_HZ = 512;
  localparam int CAL_HALF = SLOW_XTAL_HZ / CAL_OUT_HZ / 2;
  localparam int FAST_DIV = 128;

  // Widths and reset values
  localparam int PRESC_W = 20;
  localparam int COUNT_W = 32;
  localparam int BKP_W = 16;
  localparam int NUM_BKP = 10;
  localparam logic [PRESC_W-1:0] RELOAD_RESET = PRESC_W'(SLOW_XTAL_HZ - 1);
endpackage

// *** hdl/rtcb_sync.sv ***
// Three-stage pin synchroniser with agreement filter and edge pulses.
// Assumes the pin is asynchronous to the core clock.
`timescale 1ns/1ps
module rtcb_sync
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic pin_in,
  output logic level_out,
  output logic rise_out,
  output logic fall_out
);
  logic s1;
  logic s2;
  logic s3;
  logic agree;

  // Only the second stage reads the first, to let metastability settle
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level_out <= 1'b0;
    end
    else
    begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
      if (agree)
        level_out <= s2;
    end
  end

  // A change counts once stages two and three agree
  assign agree = (s2 == s3);
  assign rise_out = agree && s2 && !level_out;
  assign fall_out = agree && !s2 && level_out;
endmodule

// *** hdl/rtcb_top.sv ***
// Real-time clock with prescaler, alarm, calibration output and backup registers.
// Assumes slow clock sources arrive as pins sampled on the 250 MHz core clock,
// and that RST_IN is the main-domain reset while BKP_RST_IN resets the backup domain.
`timescale 1ns/1ps

// Summary of operation
// [R1] 32-bit counter advances once per time base tick
// [R2] Counter reaching compare value raises alarm event
// [R3] Separate alarm and periodic tick interrupts
// [R4] Source: slow crystal, low-power RC, fast clock/128
// [R5] 20-bit prescaler, reset gives one-second tick
// [R6] 512 Hz calibration clock output pin
// [R7] Ten 16-bit backup registers, backup-domain powered
// [R8] Stop and Standby never halt counting or alarm
// [R9] Alarm exits Standby, with reset, watchdog, wakeup
// [R10] Standby keeps backup registers, loses ordinary state
// [R11] Alarm also drives external event line
// [R12] Reload resets to 32767 (divide by 32768), applies at next reload
// [R13] Each interrupt has flag plus enable gate
module rtcb_top
#(
  parameter int NUM_BKP = rtcb_pkg::NUM_BKP,
  parameter logic [rtcb_pkg::PRESC_W-1:0] RESET_RELOAD = rtcb_pkg::RELOAD_RESET
)
(
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  input wire logic BKP_RST_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [31:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [31:0] REG_RDATA_OUT,
  input wire logic SLOW_XTAL_CLK_IN,
  input wire logic LOW_POWER_RC_CLK_IN,
  input wire logic FAST_EXTERNAL_CLOCK_IN,
  input wire logic WAKEUP_PIN_IN,
  input wire logic EXTERNAL_RESET_PIN_N_IN,
  input wire logic INDEPENDENT_WATCHDOG_RST_IN,
  input wire logic STANDBY_IN,
  output logic ALARM_IRQ_OUT,
  output logic TICK_IRQ_OUT,
  output logic ALARM_EVENT_OUT,
  output logic STANDBY_EXIT_OUT,
  output logic CAL_CLK_OUT
);
  localparam int PW = rtcb_pkg::PRESC_W;
  localparam int CW = rtcb_pkg::COUNT_W;
  localparam int FDW = $clog2(rtcb_pkg::FAST_DIV);
  localparam int CDW = $clog2(rtcb_pkg::CAL_HALF) + 1;

  // Synchronised pins
  logic slow_rise;
  logic rc_rise;
  logic fast_rise;
  logic wake_rise;
  logic ext_rst_fall;

  // Backup-domain state
  logic [1:0] clk_sel;
  logic cal_en;
  logic [PW-1:0] presc_reload;
  logic [PW-1:0] presc_cnt;
  logic [CW-1:0] count;
  logic [CW-1:0] alarm_val;
  logic [FDW-1:0] fast_div;
  logic [CDW-2:0] cal_div;
  logic [rtcb_pkg::BKP_W-1:0] bkp [0:NUM_BKP-1];

  // Main-domain state
  logic alarm_ie;
  logic tick_ie;
  logic alarm_flag;
  logic tick_flag;

  // Decode and datapath wires
  logic wr_ok;
  logic ctrl_wr;
  logic stat_wr;
  logic reload_wr;
  logic count_wr;
  logic alarm_wr;
  logic bkp_wr;
  logic bkp_hit;
  logic [7:0] bkp_off;
  logic [3:0] bkp_idx;
  logic fast_tick;
  logic src_edge;
  logic tick;
  logic [CW-1:0] count_inc;
  logic alarm_hit;
  logic exit_req;
  logic alarm_clr;
  logic tick_clr;
  logic [31:0] ctrl_word;
  logic [31:0] rd_mux;

  // Pin synchronisers; clock pins are sampled, the core clock far outruns them
  rtcb_sync u_slow (.clk_in(CORE_CLK_IN), .rst_in(BKP_RST_IN), .pin_in(SLOW_XTAL_CLK_IN),
    .level_out(), .rise_out(slow_rise), .fall_out());
  rtcb_sync u_rc (.clk_in(CORE_CLK_IN), .rst_in(BKP_RST_IN), .pin_in(LOW_POWER_RC_CLK_IN),
    .level_out(), .rise_out(rc_rise), .fall_out());
  rtcb_sync u_fast (.clk_in(CORE_CLK_IN), .rst_in(BKP_RST_IN),
    .pin_in(FAST_EXTERNAL_CLOCK_IN), .level_out(), .rise_out(fast_rise), .fall_out());
  rtcb_sync u_wake (.clk_in(CORE_CLK_IN), .rst_in(BKP_RST_IN), .pin_in(WAKEUP_PIN_IN),
    .level_out(), .rise_out(wake_rise), .fall_out());
  rtcb_sync u_external_reset_pin (.clk_in(CORE_CLK_IN), .rst_in(BKP_RST_IN),
    .pin_in(EXTERNAL_RESET_PIN_N_IN), .level_out(), .rise_out(), .fall_out(ext_rst_fall));

  // Register decode; the main bus is powered down in Standby, so writes drop
  assign wr_ok = REG_WR_IN && !STANDBY_IN;
  assign ctrl_wr = wr_ok && (REG_ADDR_IN == rtcb_pkg::OFF_CTRL);
  assign stat_wr = wr_ok && (REG_ADDR_IN == rtcb_pkg::OFF_STATUS);
  assign reload_wr = wr_ok && (REG_ADDR_IN == rtcb_pkg::OFF_RELOAD);
  assign count_wr = wr_ok && (REG_ADDR_IN == rtcb_pkg::OFF_COUNT);
  assign alarm_wr = wr_ok && (REG_ADDR_IN == rtcb_pkg::OFF_ALARM);
  assign bkp_off = REG_ADDR_IN - rtcb_pkg::OFF_BKP_BASE;
  assign bkp_idx = bkp_off[5:2];
  assign bkp_hit = (REG_ADDR_IN >= rtcb_pkg::OFF_BKP_BASE) && (bkp_off[1:0] == 2'h0)
    && (bkp_off < 8'(NUM_BKP * rtcb_pkg::BKP_STRIDE));
  assign bkp_wr = wr_ok && bkp_hit;

  // Clock source selection; off leaves the counter frozen
  assign fast_tick = fast_rise && (fast_div == FDW'(rtcb_pkg::FAST_DIV - 1)); // see [R4]
  assign src_edge = (clk_sel == rtcb_pkg::SEL_SLOW_XTAL) ? slow_rise :
    (clk_sel == rtcb_pkg::SEL_LOW_POWER_RC) ? rc_rise :
    (clk_sel == rtcb_pkg::SEL_FAST_DIV) ? fast_tick : 1'b0; // see [R4]

  // Tick on the source edge that finds the prescaler at zero
  assign tick = src_edge && (presc_cnt == '0); // see [R5]
  assign count_inc = count + CW'(1);
  // A software load wins over a same-cycle tick and raises no alarm
  assign alarm_hit = tick && !count_wr && (count_inc == alarm_val); // see [R2]
  // Standby exit sources, only meaningful while in Standby
  assign exit_req = STANDBY_IN && (alarm_hit || wake_rise || ext_rst_fall
    || INDEPENDENT_WATCHDOG_RST_IN); // see [R9]
  assign alarm_clr = stat_wr && REG_WDATA_IN[rtcb_pkg::STAT_ALARM];
  assign tick_clr = stat_wr && REG_WDATA_IN[rtcb_pkg::STAT_TICK];

  // Fast clock divider, free running so the ratio stays exact across selects
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (BKP_RST_IN)
      fast_div <= '0;
    else if (fast_rise)
      fast_div <= fast_div + FDW'(1); // see [R4]
  end

  // Prescaler; a new reload only lands at the next wrap, count untouched
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (BKP_RST_IN)
    begin
      presc_reload <= RESET_RELOAD; // see [R12]
      presc_cnt <= RESET_RELOAD; // see [R5]
    end
    else
    begin
      if (reload_wr)
        presc_reload <= REG_WDATA_IN[PW-1:0]; // see [R12]
      if (tick)
        presc_cnt <= presc_reload; // see [R12]
      else if (src_edge)
        presc_cnt <= presc_cnt - PW'(1); // see [R5]
    end
  end

  // Counter and compare value; STANDBY_IN is not looked at, so counting goes on
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (BKP_RST_IN)
    begin
      count <= '0;
      alarm_val <= '1;
    end
    else
    begin
      if (count_wr)
        count <= REG_WDATA_IN;
      else if (tick)
        count <= count_inc; // see [R1] see [R8]
      if (alarm_wr)
        alarm_val <= REG_WDATA_IN;
    end
  end

  // Source and calibration settings live in the backup domain
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (BKP_RST_IN)
    begin
      clk_sel <= rtcb_pkg::SEL_SLOW_XTAL;
      cal_en <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      clk_sel <= REG_WDATA_IN[rtcb_pkg::CTRL_SEL_HI:rtcb_pkg::CTRL_SEL_LO];
      cal_en <= REG_WDATA_IN[rtcb_pkg::CTRL_CAL_EN];
    end
  end

  // Calibration output: source divided by 64, i.e. 512 Hz from the crystal
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (BKP_RST_IN)
    begin
      cal_div <= '0;
      CAL_CLK_OUT <= 1'b0;
    end
    else if (!cal_en)
    begin
      cal_div <= '0;
      CAL_CLK_OUT <= 1'b0;
    end
    else if (src_edge)
    begin
      cal_div <= cal_div + (CDW-1)'(1);
      if (cal_div == (CDW-1)'(rtcb_pkg::CAL_HALF - 1))
        CAL_CLK_OUT <= !CAL_CLK_OUT; // see [R6]
    end
  end

  // Backup registers: only the backup-domain reset clears them
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (BKP_RST_IN)
    begin
      for (int i = 0; i < NUM_BKP; i++)
        bkp[i] <= '0;
    end
    else if (bkp_wr)
      bkp[bkp_idx] <= REG_WDATA_IN[rtcb_pkg::BKP_W-1:0]; // see [R7] see [R10]
  end

  // Event pulses to the wakeup logic and the external event line
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (BKP_RST_IN)
    begin
      ALARM_EVENT_OUT <= 1'b0;
      STANDBY_EXIT_OUT <= 1'b0;
    end
    else
    begin
      ALARM_EVENT_OUT <= alarm_hit; // see [R11]
      STANDBY_EXIT_OUT <= exit_req; // see [R9]
    end
  end

  // Flags and enables are ordinary registers, lost with the main domain
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
    begin
      alarm_ie <= 1'b0;
      tick_ie <= 1'b0;
      alarm_flag <= 1'b0;
      tick_flag <= 1'b0;
    end
    else
    begin
      if (ctrl_wr)
      begin
        alarm_ie <= REG_WDATA_IN[rtcb_pkg::CTRL_ALARM_IE];
        tick_ie <= REG_WDATA_IN[rtcb_pkg::CTRL_TICK_IE];
      end
      // Set beats clear so a same-cycle event is not lost
      alarm_flag <= alarm_hit || (alarm_flag && !alarm_clr); // see [R13]
      tick_flag <= tick || (tick_flag && !tick_clr); // see [R3] see [R13]
    end
  end

  // Interrupt lines, one per source, gated by their enables
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
    begin
      ALARM_IRQ_OUT <= 1'b0;
      TICK_IRQ_OUT <= 1'b0;
    end
    else
    begin
      ALARM_IRQ_OUT <= alarm_flag && alarm_ie; // see [R3] see [R13]
      TICK_IRQ_OUT <= tick_flag && tick_ie; // see [R3] see [R13]
    end
  end

  // Read mux; unmapped addresses read zero
  assign ctrl_word = {26'h0, clk_sel, 1'b0, cal_en, tick_ie, alarm_ie};
  assign rd_mux = (REG_ADDR_IN == rtcb_pkg::OFF_CTRL) ? ctrl_word :
    (REG_ADDR_IN == rtcb_pkg::OFF_STATUS) ? {30'h0, tick_flag, alarm_flag} :
    (REG_ADDR_IN == rtcb_pkg::OFF_RELOAD) ? {12'h0, presc_reload} :
    (REG_ADDR_IN == rtcb_pkg::OFF_DIVIDER) ? {12'h0, presc_cnt} :
    (REG_ADDR_IN == rtcb_pkg::OFF_COUNT) ? count :
    (REG_ADDR_IN == rtcb_pkg::OFF_ALARM) ? alarm_val :
    bkp_hit ? {16'h0, bkp[bkp_idx]} : 32'h0;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
      REG_RDATA_OUT <= 32'h0;
    else if (REG_RD_IN)
      REG_RDATA_OUT <= rd_mux;
    else
      REG_RDATA_OUT <= 32'h0;
  end

  // Checks
  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (RST_IN || BKP_RST_IN);

  property p_count_adv;
    tick && !count_wr |=> count == $past(count) + 32'h1;
  endproperty
  a_count_adv: assert property (p_count_adv) else $error("count missed tick"); // see [R1]

  property p_alarm_flag;
    alarm_hit |=> alarm_flag ##1 ALARM_IRQ_OUT == alarm_ie;
  endproperty
  a_alarm_flag: assert property (p_alarm_flag) else $error("alarm not flagged"); // see [R2]

  property p_tick_flag;
    tick |=> tick_flag;
  endproperty
  a_tick_flag: assert property (p_tick_flag) else $error("tick not flagged"); // see [R3]

  property p_fast_sel;
    clk_sel == rtcb_pkg::SEL_FAST_DIV && src_edge |-> fast_rise && fast_div == 7'h7f;
  endproperty
  a_fast_sel: assert property (p_fast_sel) else $error("fast divide wrong"); // see [R4]

  property p_presc_wrap;
    tick |=> presc_cnt == $past(presc_reload) && count != $past(count) || $past(count_wr);
  endproperty
  a_presc_wrap: assert property (p_presc_wrap) else $error("prescaler reload wrong"); // see [R5]

  property p_cal_toggle;
    cal_en && src_edge && cal_div == 5'h1f |=> CAL_CLK_OUT != $past(CAL_CLK_OUT);
  endproperty
  a_cal_toggle: assert property (p_cal_toggle) else $error("cal output stuck"); // see [R6]

  property p_bkp_write;
    bkp_wr |=> bkp[$past(bkp_idx)] == $past(REG_WDATA_IN[15:0]);
  endproperty
  a_bkp_write: assert property (p_bkp_write) else $error("backup write lost"); // see [R7]

  property p_standby_count;
    STANDBY_IN && tick |=> count == $past(count) + 32'h1;
  endproperty
  a_standby_count: assert property (p_standby_count) else $error("standby stopped rtc"); // see [R8]

  property p_standby_exit;
    STANDBY_IN && alarm_hit |=> STANDBY_EXIT_OUT && ALARM_EVENT_OUT;
  endproperty
  a_standby_exit: assert property (p_standby_exit) else $error("alarm no exit"); // see [R9]

  property p_bkp_keep;
    @(posedge CORE_CLK_IN) disable iff (BKP_RST_IN)
    RST_IN && !bkp_wr |=> bkp[0] == $past(bkp[0]);
  endproperty
  a_bkp_keep: assert property (p_bkp_keep) else $error("backup lost on reset"); // see [R10]

  property p_event_line;
    ALARM_EVENT_OUT |-> $past(alarm_hit) ##1 !ALARM_EVENT_OUT || $past(alarm_hit);
  endproperty
  a_event_line: assert property (p_event_line) else $error("spurious alarm event"); // see [R11]

  property p_irq_gate;
    !tick_ie ##1 !tick_ie |-> !TICK_IRQ_OUT;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("tick irq ungated"); // see [R13]

  c_alarm: cover property (alarm_hit);
  c_exit: cover property (STANDBY_IN && alarm_hit ##1 STANDBY_EXIT_OUT);
  c_fast: cover property (fast_tick && clk_sel == rtcb_pkg::SEL_FAST_DIV);
  c_cal: cover property ($rose(CAL_CLK_OUT));
endmodule
